// ### src/modbus_slave_exception_clock_map.svh
/*
 * register offsets, value limits, reset values and timing counts of the
 * slave exception checker and its calendar clock.
 * assumes inclusion by bare name from the design modules, the monitor and the bench.
 */
`ifndef MODBUS_SLAVE_EXCEPTION_CLOCK_MAP_SVH
`define MODBUS_SLAVE_EXCEPTION_CLOCK_MAP_SVH

// ==========================================================================
// register offsets (word addresses on the serial link)
`define OFS_CLOCK_HOURS_VALUE 16'h4010
`define OFS_CLOCK_MINUTES_VALUE 16'h4011
`define OFS_CLOCK_SECONDS_VALUE 16'h4012
`define OFS_CLOCK_DAY_OF_MONTH 16'h4013
`define OFS_CLOCK_YEAR_VALUE 16'h4014
`define OFS_ZONE_OFFSET_FROM_UTC 16'h4015
`define OFS_CLOCK_MONTH_SELECT 16'h4089

// ==========================================================================
// value limits
`define LIM_HOURS_MAX 16'h0017
`define LIM_MIN_SEC_MAX 16'h003B
`define LIM_DAY_MIN 16'h0001
`define LIM_DAY_MAX 16'h001F
`define LIM_MONTH_MAX 16'h000C
`define LIM_YEAR_MIN 16'h07D5
`define LIM_YEAR_MAX 16'h0833
`define LIM_ZONE_MIN 16'hFB50
`define LIM_ZONE_MAX 16'h0514

// ==========================================================================
// reset values
`define RST_HOURS 16'h0000
`define RST_MINUTES 16'h0000
`define RST_SECONDS 16'h0000
`define RST_DAY 16'h0001
`define RST_MONTH 16'h0001
`define RST_YEAR 16'h07D5
`define RST_ZONE 16'h0000

// ==========================================================================
// function codes, exception flag and timing
`define FC_READ_HOLDING 8'h03
`define FC_WRITE_SINGLE 8'h06
`define FC_READ_RECORD 8'h14
`define EXC_FLAG 8'h80
`define REPLY_BUF_WORDS 16
`define SECOND_TIME_MS 1000
`define CLK_FREQ_KHZ 25000
`define TICK_CYCLES (`SECOND_TIME_MS * `CLK_FREQ_KHZ)

`endif

// ### src/modbus_slave_exception_clock_pkg.sv
/*
 * types shared by the exception checker and its calendar clock.
 * uses no macro of the map header and does not include it.
 */
`default_nettype none
package modbus_slave_exception_clock_pkg;

	// ======================================================================
	// calendar field selector for loads
	typedef enum logic [2:0] {
		FLD_HOURS = 3'h0,
		FLD_MINUTES = 3'h1,
		FLD_SECONDS = 3'h2,
		FLD_DAY = 3'h3,
		FLD_YEAR = 3'h4,
		FLD_MONTH = 3'h5
	} clock_field_t;

	// ======================================================================
	// exception codes returned in the data field
	typedef enum logic [7:0] {
		EXC_NONE = 8'h00,
		EXC_ILLEGAL_FUNCTION = 8'h01,
		EXC_ILLEGAL_ADDRESS = 8'h02,
		EXC_ILLEGAL_VALUE = 8'h03,
		EXC_DEVICE_FAILURE = 8'h04,
		EXC_DEVICE_BUSY = 8'h06,
		EXC_NEG_ACK = 8'h07,
		EXC_BUFFER_OVERFLOW = 8'h09
	} exc_code_t;

	// ======================================================================
	// request handling states, one-hot
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_CHECK = 3'b010,
		ST_REPLY = 3'b100
	} req_state_t;

endpackage
`default_nettype wire

// ### src/clock_calendar.sv
/*
 * calendar clock: seconds, minutes, hours, day, month and year counters
 * advanced by a one-second prescaler, with single-field loads.
 * assumes loads arrive already range-checked from the request checker.
 */
`timescale 1ns/100ps
`default_nettype none
`include "modbus_slave_exception_clock_map.svh"

module clock_calendar
#(
	parameter int unsigned TICK_CYCLES = `TICK_CYCLES
)
(
	input wire logic i_core_clk,
	input wire logic i_resetn,
	input wire logic i_load,
	input wire modbus_slave_exception_clock_pkg::clock_field_t i_load_sel,
	input wire logic [15:0] i_load_val,
	output logic [15:0] o_hours,
	output logic [15:0] o_minutes,
	output logic [15:0] o_seconds,
	output logic [15:0] o_day,
	output logic [15:0] o_month,
	output logic [15:0] o_year
);
	import modbus_slave_exception_clock_pkg::*;

	logic [31:0] presc_q;
	logic tick_q;
	logic [15:0] hours_q, minutes_q, seconds_q, day_q, month_q, year_q;
	logic [15:0] last_day;
	logic leap;

	// ======================================================================
	// one-second prescaler
	always_ff @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			presc_q <= 32'h0000_0000;
			tick_q <= 1'b0;
		end
		else if (presc_q == 32'(TICK_CYCLES - 1))
		begin
			presc_q <= 32'h0000_0000;
			tick_q <= 1'b1;
		end
		else
		begin
			presc_q <= presc_q + 32'h0000_0001;
			tick_q <= 1'b0;
		end
	end

	// length of the running month; month 0 (unused) counts as 31 days
	assign leap = (year_q[1:0] == 2'b00); // exact for 2005 to 2099
	always_comb
	begin
		case (month_q)
			16'h0002: last_day = leap ? 16'h001D : 16'h001C;
			16'h0004, 16'h0006, 16'h0009, 16'h000B: last_day = 16'h001E;
			default: last_day = `LIM_DAY_MAX;
		endcase
	end

	// ======================================================================
	// counters; a load wins over the tick of the same cycle
	always_ff @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			hours_q <= `RST_HOURS;
			minutes_q <= `RST_MINUTES;
			seconds_q <= `RST_SECONDS;
			day_q <= `RST_DAY;
			month_q <= `RST_MONTH;
			year_q <= `RST_YEAR;
		end
		else if (i_load)
		begin
			case (i_load_sel)
				FLD_HOURS: hours_q <= i_load_val;
				FLD_MINUTES: minutes_q <= i_load_val;
				FLD_SECONDS: seconds_q <= i_load_val;
				FLD_DAY: day_q <= i_load_val;
				FLD_YEAR: year_q <= i_load_val;
				FLD_MONTH: month_q <= i_load_val;
				default: hours_q <= hours_q;
			endcase
		end
		else if (tick_q)
		begin
			seconds_q <= seconds_q + 16'h0001;
			if (seconds_q >= `LIM_MIN_SEC_MAX)
			begin
				seconds_q <= 16'h0000;
				minutes_q <= minutes_q + 16'h0001;
				if (minutes_q >= `LIM_MIN_SEC_MAX)
				begin
					minutes_q <= 16'h0000;
					hours_q <= hours_q + 16'h0001;
					if (hours_q >= `LIM_HOURS_MAX)
					begin
						hours_q <= 16'h0000;
						day_q <= day_q + 16'h0001;
						// an unused month never carries into the year
						if (day_q >= last_day)
						begin
							day_q <= `LIM_DAY_MIN;
							if (month_q != 16'h0000)
							begin
								month_q <= month_q + 16'h0001;
								if (month_q >= `LIM_MONTH_MAX)
								begin
									month_q <= 16'h0001;
									// past the last year the clock wraps
									year_q <= (year_q >= `LIM_YEAR_MAX) ?
										`LIM_YEAR_MIN :
										year_q + 16'h0001;
								end
							end
						end
					end
				end
			end
		end
	end

	assign o_hours = hours_q;
	assign o_minutes = minutes_q;
	assign o_seconds = seconds_q;
	assign o_day = day_q;
	assign o_month = month_q;
	assign o_year = year_q;

endmodule
`default_nettype wire

// ### src/modbus_slave_exception_clock.sv
/*
 * request checker of a serial slave: decides between a normal reply, an
 * exception reply and silence, and serves the calendar clock registers.
 * assumes a framer in front that delivers one decoded request per pulse
 * with its error flag, and a sender behind that forms the reply frame.
 */
`timescale 1ns/100ps
`default_nettype none
`include "modbus_slave_exception_clock_map.svh"

module modbus_slave_exception_clock
#(
	parameter int unsigned TICK_CYCLES = `TICK_CYCLES,
	parameter int unsigned BUF_WORDS = `REPLY_BUF_WORDS
)
(
	input wire logic i_core_clk,
	input wire logic i_resetn,
	input wire logic i_req_valid,
	input wire logic i_req_frame_err,
	input wire logic [7:0] i_req_func,
	input wire logic [15:0] i_req_addr,
	input wire logic [15:0] i_req_count,
	input wire logic [15:0] i_req_wdata,
	input wire logic i_dev_fault,
	input wire logic i_dev_busy,
	input wire logic i_dev_nak,
	output logic o_req_ready,
	output logic o_rsp_valid,
	output logic o_rsp_drop,
	output logic o_rsp_is_exc,
	output logic [7:0] o_rsp_func,
	output modbus_slave_exception_clock_pkg::exc_code_t o_rsp_code,
	output logic [15:0] o_rsp_data,
	output logic [15:0] o_zone_offset
);
	import modbus_slave_exception_clock_pkg::*;

	req_state_t state_q, state_d;
	logic frame_err_q, fault_q, busy_q, nak_q;
	logic [7:0] func_q;
	logic [15:0] addr_q, count_q, wdata_q;
	logic [15:0] zone_q;
	logic [15:0] hours, minutes, seconds, day, month, year;
	logic addr_ok, value_ok, is_zone;
	logic [15:0] read_val;
	clock_field_t fld;
	exc_code_t code_d;
	logic load;
	logic ready_q, rsp_valid_q, rsp_drop_q, rsp_is_exc_q;
	logic [7:0] rsp_func_q;
	exc_code_t rsp_code_q;
	logic [15:0] rsp_data_q;

	// ======================================================================
	// request sequencing: take, check, reply
	always_comb
	begin
		case (state_q)
			ST_IDLE: state_d = i_req_valid ? ST_CHECK : ST_IDLE;
			ST_CHECK: state_d = ST_REPLY;
			ST_REPLY: state_d = ST_IDLE;
			default: state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			state_q <= ST_IDLE;
		else
			state_q <= state_d;
	end

	// ready is low from the take until the reply has gone out
	always_ff @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			ready_q <= 1'b1;
		else
			ready_q <= (state_d == ST_IDLE);
	end

	// ======================================================================
	// request capture; device state is sampled with the request so a
	// status change mid-check cannot split one decision
	always_ff @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			frame_err_q <= 1'b0;
			fault_q <= 1'b0;
			busy_q <= 1'b0;
			nak_q <= 1'b0;
			func_q <= 8'h00;
			addr_q <= 16'h0000;
			count_q <= 16'h0000;
			wdata_q <= 16'h0000;
		end
		else if (state_q == ST_IDLE && i_req_valid)
		begin
			frame_err_q <= i_req_frame_err;
			fault_q <= i_dev_fault;
			busy_q <= i_dev_busy;
			nak_q <= i_dev_nak;
			func_q <= i_req_func;
			addr_q <= i_req_addr;
			count_q <= i_req_count;
			wdata_q <= i_req_wdata;
		end
	end

	// ======================================================================
	// address decode, readback and per-field range check
	always_comb
	begin
		addr_ok = 1'b1;
		value_ok = 1'b0;
		is_zone = 1'b0;
		fld = FLD_HOURS;
		read_val = 16'h0000;
		case (addr_q)
			`OFS_CLOCK_HOURS_VALUE:
			begin
				read_val = hours;
				value_ok = (wdata_q <= `LIM_HOURS_MAX);
			end
			`OFS_CLOCK_MINUTES_VALUE:
			begin
				fld = FLD_MINUTES;
				read_val = minutes;
				value_ok = (wdata_q <= `LIM_MIN_SEC_MAX);
			end
			`OFS_CLOCK_SECONDS_VALUE:
			begin
				fld = FLD_SECONDS;
				read_val = seconds;
				value_ok = (wdata_q <= `LIM_MIN_SEC_MAX);
			end
			`OFS_CLOCK_DAY_OF_MONTH:
			begin
				fld = FLD_DAY;
				read_val = day;
				value_ok = (wdata_q >= `LIM_DAY_MIN) &&
					(wdata_q <= `LIM_DAY_MAX);
			end
			`OFS_CLOCK_YEAR_VALUE:
			begin
				fld = FLD_YEAR;
				read_val = year;
				value_ok = (wdata_q >= `LIM_YEAR_MIN) &&
					(wdata_q <= `LIM_YEAR_MAX);
			end
			`OFS_CLOCK_MONTH_SELECT:
			begin
				fld = FLD_MONTH;
				read_val = month;
				value_ok = (wdata_q <= `LIM_MONTH_MAX);
			end
			`OFS_ZONE_OFFSET_FROM_UTC:
			begin
				is_zone = 1'b1;
				read_val = zone_q;
				// signed hhmm compare
				value_ok = ($signed(wdata_q) >= $signed(`LIM_ZONE_MIN)) &&
					($signed(wdata_q) <= $signed(`LIM_ZONE_MAX));
			end
			default: addr_ok = 1'b0;
		endcase
	end

	// ======================================================================
	// exception decision, first match wins: function, device state,
	// address, then count or value
	always_comb
	begin
		code_d = EXC_NONE;
		if (func_q != `FC_READ_HOLDING && func_q != `FC_WRITE_SINGLE &&
			func_q != `FC_READ_RECORD)
			code_d = EXC_ILLEGAL_FUNCTION;
		else if (fault_q)
			code_d = EXC_DEVICE_FAILURE;
		else if (busy_q)
			code_d = EXC_DEVICE_BUSY;
		else if (nak_q)
			code_d = EXC_NEG_ACK;
		else if (!addr_ok)
			code_d = EXC_ILLEGAL_ADDRESS;
		else if (func_q == `FC_READ_RECORD)
		begin
			if (count_q > 16'(BUF_WORDS))
				code_d = EXC_BUFFER_OVERFLOW;
		end
		else if (func_q == `FC_READ_HOLDING)
		begin
			// one register per read: any other quantity is a bad value
			if (count_q != 16'h0001)
				code_d = EXC_ILLEGAL_VALUE;
		end
		else if (!value_ok)
			code_d = EXC_ILLEGAL_VALUE;
	end

	// an accepted write lands in the check cycle; rejected ones never do
	assign load = (state_q == ST_CHECK) && !frame_err_q &&
		(func_q == `FC_WRITE_SINGLE) && (code_d == EXC_NONE) && !is_zone;

	// ======================================================================
	// zone offset: stored and read back only, steers nothing else
	always_ff @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			zone_q <= `RST_ZONE;
		else if ((state_q == ST_CHECK) && !frame_err_q && is_zone &&
			(func_q == `FC_WRITE_SINGLE) && (code_d == EXC_NONE))
			zone_q <= wdata_q;
	end

	clock_calendar #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_calendar (
		.i_core_clk(i_core_clk),
		.i_resetn(i_resetn),
		.i_load(load),
		.i_load_sel(fld),
		.i_load_val(wdata_q),
		.o_hours(hours),
		.o_minutes(minutes),
		.o_seconds(seconds),
		.o_day(day),
		.o_month(month),
		.o_year(year)
	);

	// ======================================================================
	// reply build; a corrupted frame is dropped without any reply
	always_ff @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			rsp_valid_q <= 1'b0;
			rsp_drop_q <= 1'b0;
			rsp_is_exc_q <= 1'b0;
			rsp_func_q <= 8'h00;
			rsp_code_q <= EXC_NONE;
			rsp_data_q <= 16'h0000;
		end
		else if (state_q == ST_CHECK)
		begin
			rsp_valid_q <= !frame_err_q;
			rsp_drop_q <= frame_err_q;
			rsp_is_exc_q <= !frame_err_q && (code_d != EXC_NONE);
			if (code_d != EXC_NONE)
			begin
				rsp_func_q <= func_q | `EXC_FLAG;
				rsp_code_q <= code_d;
				rsp_data_q <= {8'h00, code_d};
			end
			else
			begin
				rsp_func_q <= func_q;
				rsp_code_q <= EXC_NONE;
				// a write echoes its value, reads return the register
				rsp_data_q <= (func_q == `FC_WRITE_SINGLE) ?
					wdata_q : read_val;
			end
		end
		else
		begin
			rsp_valid_q <= 1'b0;
			rsp_drop_q <= 1'b0;
		end
	end

	assign o_req_ready = ready_q;
	assign o_rsp_valid = rsp_valid_q;
	assign o_rsp_drop = rsp_drop_q;
	assign o_rsp_is_exc = rsp_is_exc_q;
	assign o_rsp_func = rsp_func_q;
	assign o_rsp_code = rsp_code_q;
	assign o_rsp_data = rsp_data_q;
	assign o_zone_offset = zone_q;

endmodule
`default_nettype wire

// ### test/modbus_slave_exception_clock_monitor.sv
/*
 * checker of the slave request checker: reply timing, echo and codes.
 * assumes binding to the top module, map header on the include path.
 */
`timescale 1ns/100ps
`default_nettype none
`include "modbus_slave_exception_clock_map.svh"

module modbus_slave_exception_clock_monitor
#(
	parameter int unsigned TICK_CYCLES = 4,
	parameter int unsigned BUF_WORDS = 16
)
(
	input wire logic i_core_clk,
	input wire logic i_resetn,
	input wire logic i_req_valid,
	input wire logic i_req_frame_err,
	input wire logic [7:0] i_req_func,
	input wire logic [15:0] i_req_addr,
	input wire logic [15:0] i_req_count,
	input wire logic i_dev_fault,
	input wire logic i_dev_busy,
	input wire logic i_dev_nak,
	input wire logic o_req_ready,
	input wire logic o_rsp_valid,
	input wire logic o_rsp_drop,
	input wire logic o_rsp_is_exc,
	input wire logic [7:0] o_rsp_func,
	input wire modbus_slave_exception_clock_pkg::exc_code_t o_rsp_code,
	input wire logic [15:0] o_rsp_data,
	input wire logic [15:0] o_zone_offset
);
	import modbus_slave_exception_clock_pkg::*;

	// ==================================================================
	// decode helpers; frame errors excluded from take
	logic take;
	logic fn_ok;
	logic st_ok;
	logic adr_ok;
	assign take = i_req_valid && o_req_ready && !i_req_frame_err;
	assign fn_ok = i_req_func inside {8'h03, 8'h06, 8'h14};
	assign st_ok = !i_dev_fault && !i_dev_busy && !i_dev_nak;
	assign adr_ok = i_req_addr inside {[16'h4010:16'h4015], 16'h4089};

	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_resetn);

	// ==================================================================
	// sequences: request taken, exception reply two edges later
	sequence s_take;
		i_req_valid && o_req_ready;
	endsequence
	sequence s_exc(exc_code_t c);
		##2 o_rsp_valid && o_rsp_is_exc && o_rsp_code == c;
	endsequence

	// ==================================================================
	// assertions
	a_ready_cycle:
		assert property (s_take |=> !o_req_ready [*2] ##1 o_req_ready)
		else $error("ready not low for reply cycle");
	a_frame_silent:
		assert property (s_take ##0 i_req_frame_err
			|-> ##2 o_rsp_drop && !o_rsp_valid)
		else $error("bad frame not dropped");
	a_echo_func:
		assert property (take |-> ##2 o_rsp_valid
			&& (o_rsp_is_exc || o_rsp_func == $past(i_req_func, 2)))
		else $error("function not echoed");
	a_exc_top_bit:
		assert property (take |-> ##2 (!o_rsp_is_exc
			|| o_rsp_func == ($past(i_req_func, 2) | `EXC_FLAG)))
		else $error("exception top bit wrong");
	a_exc_one_code:
		assert property (o_rsp_valid && o_rsp_is_exc |-> o_rsp_code
			!= EXC_NONE && o_rsp_data == {8'h00, o_rsp_code})
		else $error("exception data wrong");
	a_bad_func:
		assert property (take && !fn_ok |-> s_exc(EXC_ILLEGAL_FUNCTION))
		else $error("code 01 missing");
	a_dev_fault:
		assert property (take && fn_ok && i_dev_fault
			|-> s_exc(EXC_DEVICE_FAILURE))
		else $error("code 04 missing");
	a_dev_busy:
		assert property (take && fn_ok && !i_dev_fault && i_dev_busy
			|-> s_exc(EXC_DEVICE_BUSY))
		else $error("code 06 missing");
	a_dev_nak:
		assert property (take && fn_ok && !i_dev_fault && !i_dev_busy
			&& i_dev_nak |-> s_exc(EXC_NEG_ACK))
		else $error("code 07 missing");
	a_bad_addr:
		assert property (take && fn_ok && st_ok && !adr_ok
			|-> s_exc(EXC_ILLEGAL_ADDRESS))
		else $error("code 02 missing");
	a_buf_over:
		assert property (take && st_ok && adr_ok && i_req_func == 8'h14
			&& i_req_count > BUF_WORDS |-> s_exc(EXC_BUFFER_OVERFLOW))
		else $error("code 09 missing");
	a_zone_range:
		assert property ($signed(o_zone_offset) >= $signed(`LIM_ZONE_MIN)
			&& $signed(o_zone_offset) <= $signed(`LIM_ZONE_MAX))
		else $error("zone offset out of range");
endmodule

bind modbus_slave_exception_clock modbus_slave_exception_clock_monitor
	#(.TICK_CYCLES(TICK_CYCLES), .BUF_WORDS(BUF_WORDS))
	modbus_slave_exception_clock_monitor_inst (.i_core_clk, .i_resetn,
	.i_req_valid, .i_req_frame_err, .i_req_func, .i_req_addr,
	.i_req_count, .i_dev_fault, .i_dev_busy, .i_dev_nak, .o_req_ready,
	.o_rsp_valid, .o_rsp_drop, .o_rsp_is_exc, .o_rsp_func, .o_rsp_code,
	.o_rsp_data, .o_zone_offset);
`default_nettype wire

// ### test/modbus_master_model.sv
/*
 * behavioural serial master: presents one decoded query, waits for the
 * reply under a timeout and tells exception from normal replies.
 * assumes the slave request checker on the far side, same clock.
 */
`timescale 1ns/100ps
`default_nettype none

module modbus_master_model
(
	input wire logic i_core_clk,
	input wire logic i_req_ready,
	input wire logic i_rsp_valid,
	input wire logic i_rsp_drop,
	input wire logic [7:0] i_rsp_func,
	input wire logic [15:0] i_rsp_data,
	output logic o_req_valid,
	output logic o_req_frame_err,
	output logic [7:0] o_req_func,
	output logic [15:0] o_req_addr,
	output logic [15:0] o_req_count,
	output logic [15:0] o_req_wdata
);
	// ==================================================================
	// idle lines at time zero
	initial
	begin
		o_req_valid = 1'b0;
		o_req_frame_err = 1'b0;
		o_req_func = 8'h00;
		o_req_addr = 16'h0000;
		o_req_count = 16'h0000;
		o_req_wdata = 16'h0000;
	end

	// one query; fields flip after the take so stale data never looks valid
	task query(input logic [7:0] f, input logic [15:0] a, c, w,
		input logic fe, output logic got, exc, output logic [7:0] fo,
		output logic [15:0] d, output logic dr);
		int n;
		@(posedge i_core_clk);
		o_req_valid <= 1'b1;
		o_req_frame_err <= fe;
		o_req_func <= f;
		o_req_addr <= a;
		o_req_count <= c;
		o_req_wdata <= w;
		#1;
		while (!i_req_ready)
		begin
			@(posedge i_core_clk);
			#1;
		end
		@(posedge i_core_clk);
		o_req_valid <= 1'b0;
		o_req_frame_err <= ~fe;
		o_req_func <= ~f;
		o_req_addr <= ~a;
		o_req_count <= ~c;
		o_req_wdata <= ~w;
		got = 1'b0;
		dr = 1'b0;
		n = 0;
		// silence past the limit means the query timed out
		while (!got && n < 8)
		begin
			@(posedge i_core_clk);
			#1;
			got = i_rsp_valid;
			dr = dr | i_rsp_drop;
			n++;
		end
		exc = i_rsp_func[7];
		fo = i_rsp_func;
		d = exc ? {8'h00, i_rsp_data[7:0]} : i_rsp_data;
	endtask
endmodule
`default_nettype wire

// ### test/modbus_slave_exception_clock_tb.sv
/*
 * self-checking bench of the slave request checker and calendar clock.
 * assumes the map header on the include path and the master model.
 */
`timescale 1ns/100ps
`default_nettype none
`include "modbus_slave_exception_clock_map.svh"

module modbus_slave_exception_clock_tb;
	import modbus_slave_exception_clock_pkg::*;
	localparam int unsigned TICKS = 4;
	localparam int unsigned BUFW = 16;
	localparam logic [15:0] BAD_A [10] = '{16'h4010, 16'h4011,
		16'h4012, 16'h4013, 16'h4013, 16'h4089, 16'h4014, 16'h4014,
		16'h4015, 16'h4015};
	localparam logic [15:0] BAD_V [10] = '{16'h0018, 16'h003C,
		16'h003C, 16'h0000, 16'h0020, 16'h000D, 16'h07D4, 16'h0834,
		16'h0515, 16'hFB4F};
	localparam logic [15:0] CAL_A [6] = '{16'h4012, 16'h4014,
		16'h4089, 16'h4013, 16'h4010, 16'h4011};
	localparam logic [15:0] CAL_V [6] = '{16'h0000, 16'h07D5,
		16'h000C, 16'h001F, 16'h0017, 16'h003B};
	// read order of the reset check: hours, day, month, year, zone
	localparam logic [15:0] RA [5] = '{16'h4010, 16'h4013, 16'h4089,
		16'h4014, 16'h4015};
	localparam logic [15:0] RV [5] = '{`RST_HOURS, `RST_DAY,
		`RST_MONTH, `RST_YEAR, `RST_ZONE};
	localparam exc_code_t SC [3] = '{EXC_DEVICE_FAILURE,
		EXC_DEVICE_BUSY, EXC_NEG_ACK};
	logic clk = 1'b0;
	logic resetn;
	logic fault;
	logic busy;
	logic nak;
	logic req_valid, ferr, ready, rsp_valid, drop, is_exc;
	logic [7:0] func, rsp_func, fo;
	logic [15:0] addr, cnt, wdata, rsp_data, zone, d;
	exc_code_t rsp_code;
	logic got, exc, dr;
	int n_fail = 0;
	int check_count = 0;

	// ==================================================================
	// clock, design and far-side master
	always #20 clk = ~clk;

	modbus_slave_exception_clock #(.TICK_CYCLES(TICKS), .BUF_WORDS(BUFW))
		modbus_slave_exception_clock_inst (.i_core_clk(clk),
		.i_resetn(resetn), .i_req_valid(req_valid),
		.i_req_frame_err(ferr), .i_req_func(func), .i_req_addr(addr),
		.i_req_count(cnt), .i_req_wdata(wdata), .i_dev_fault(fault),
		.i_dev_busy(busy), .i_dev_nak(nak), .o_req_ready(ready),
		.o_rsp_valid(rsp_valid), .o_rsp_drop(drop), .o_rsp_is_exc(is_exc),
		.o_rsp_func(rsp_func), .o_rsp_code(rsp_code),
		.o_rsp_data(rsp_data), .o_zone_offset(zone));

	modbus_master_model modbus_master_model_inst (.i_core_clk(clk),
		.i_req_ready(ready), .i_rsp_valid(rsp_valid), .i_rsp_drop(drop),
		.i_rsp_func(rsp_func), .i_rsp_data(rsp_data),
		.o_req_valid(req_valid), .o_req_frame_err(ferr),
		.o_req_func(func), .o_req_addr(addr), .o_req_count(cnt),
		.o_req_wdata(wdata));

	// ==================================================================
	// shared helpers
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e)
		begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task q(input logic [7:0] f, input logic [15:0] a, c, w, input logic fe);
		modbus_master_model_inst.query(f, a, c, w, fe, got, exc, fo, d, dr);
	endtask

	task want_exc(input logic [7:0] f, input exc_code_t c);
		chk("exc flag", 16'h0001, {15'h0000, is_exc});
		chk("master exc", 16'h0001, {15'h0000, exc});
		chk("exc func", {8'h00, f | `EXC_FLAG}, {8'h00, fo});
		chk("exc data", {8'h00, c}, d);
		chk("exc code", {8'h00, c}, {8'h00, rsp_code});
	endtask

	// ==================================================================
	// scenarios
	task t_reset;
		chk("ready", 16'h0001, {15'h0000, ready});
		for (int i = 0; i < 5; i++)
		begin
			q(8'h03, RA[i], 16'h0001, 16'h0000, 1'b0);
			chk("reset value", RV[i], d);
		end
	endtask

	task t_zone;
		q(8'h06, 16'h4015, 16'h0001, `LIM_ZONE_MIN, 1'b0);
		chk("echo func", 16'h0006, {8'h00, fo});
		chk("echo data", `LIM_ZONE_MIN, d);
		chk("master normal", 16'h0000, {15'h0000, exc});
		chk("zone out", `LIM_ZONE_MIN, zone);
		q(8'h06, 16'h4015, 16'h0001, `LIM_ZONE_MAX, 1'b0);
		q(8'h03, 16'h4015, 16'h0001, 16'h0000, 1'b0);
		chk("zone read", `LIM_ZONE_MAX, d);
	endtask

	task t_range;
		for (int i = 0; i < 10; i++)
		begin
			q(8'h06, BAD_A[i], 16'h0001, BAD_V[i], 1'b0);
			want_exc(8'h06, EXC_ILLEGAL_VALUE);
		end
		q(8'h03, 16'h4015, 16'h0001, 16'h0000, 1'b0);
		chk("zone kept", `LIM_ZONE_MAX, d);
	endtask

	task t_codes;
		q(8'h03, 16'h4016, 16'h0001, 16'h0000, 1'b0);
		want_exc(8'h03, EXC_ILLEGAL_ADDRESS);
		q(8'h10, 16'h4010, 16'h0001, 16'h0000, 1'b0);
		want_exc(8'h10, EXC_ILLEGAL_FUNCTION);
		for (int i = 0; i < 3; i++)
		begin
			@(posedge clk);
			{fault, busy, nak} <= 3'b100 >> i;
			q(8'h03, 16'h4010, 16'h0001, 16'h0000, 1'b0);
			want_exc(8'h03, SC[i]);
		end
		@(posedge clk);
		{fault, busy, nak} <= 3'b000;
	endtask

	task t_buffer;
		q(8'h14, 16'h4010, 16'(BUFW + 1), 16'h0000, 1'b0);
		want_exc(8'h14, EXC_BUFFER_OVERFLOW);
		q(8'h03, 16'h4010, 16'(BUFW + 1), 16'h0000, 1'b0);
		want_exc(8'h03, EXC_ILLEGAL_VALUE);
		q(8'h14, 16'h4010, 16'(BUFW), 16'h0000, 1'b0);
		chk("record func", 16'h0014, {8'h00, fo});
	endtask

	task t_frame;
		q(8'h06, 16'h4010, 16'h0001, 16'h0005, 1'b1);
		chk("no reply", 16'h0000, {15'h0000, got});
		chk("dropped", 16'h0001, {15'h0000, dr});
		q(8'h03, 16'h4010, 16'h0001, 16'h0000, 1'b0);
		chk("hours kept", 16'h0000, d);
	endtask

	// set 23:59:59 on 31 december, then roll everything over
	task t_calendar;
		for (int i = 0; i < 7; i++)
			q(8'h06, i < 6 ? CAL_A[i] : 16'h4012, 16'h0001,
				i < 6 ? CAL_V[i] : 16'h003B, 1'b0);
		repeat (2 * TICKS) @(posedge clk);
		for (int i = 1; i < 6; i++)
		begin
			q(8'h03, CAL_A[i], 16'h0001, 16'h0000, 1'b0);
			chk("rollover", i == 1 ? 16'h07D6 : (i == 4 ? 16'h0000 :
				(i == 5 ? 16'h0000 : 16'h0001)), d);
		end
	endtask

	task end_of_test;
		$display("checks %0d failures %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ==================================================================
	// main sequence; device state inputs idle low
	initial
	begin
		resetn = 1'b0;
		{fault, busy, nak} = 3'b000;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		t_reset;
		t_zone;
		t_range;
		t_codes;
		t_buffer;
		t_frame;
		t_calendar;
		end_of_test;
	end

	// watchdog well beyond the ~145 cycles the scenarios need
	initial
	begin
		repeat (4000) @(posedge clk);
		n_fail++;
		$display("ERROR watchdog expected end seen hang");
		end_of_test;
	end
endmodule
`default_nettype wire
